// file: src/dfo_pkg.sv
// constants, types and helpers for the frame overhead peer controller
package dfo_pkg;

  // register byte offsets
  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_EOC_TX     = 8'h04;
  localparam logic [7:0]  ADDR_STATUS     = 8'h08;
  localparam logic [7:0]  ADDR_EOC_RX     = 8'h0c;
  localparam logic [7:0]  ADDR_ERR_CNT    = 8'h10;

  // control fields
  localparam int          CTRL_EN_BIT     = 0;
  localparam int          CTRL_ROLE_BIT   = 1;
  localparam int          CTRL_CFG_LSB    = 2;
  localparam int          CTRL_STUFF_BIT  = 4;
  localparam int          CTRL_FILL_BIT   = 5;
  localparam int          CTRL_W          = 6;
  localparam logic [5:0]  CTRL_RESET      = 6'h00;

  // maintenance transmit fields
  localparam int          EOC_INFO_LSB    = 0;
  localparam int          EOC_DM_BIT      = 8;
  localparam int          EOC_FIRST_BIT   = 9;
  localparam int          EOC_ADDR_LSB    = 10;
  localparam int          EOC_OE_BIT      = 12;
  localparam logic [7:0]  EOC_INFO_RESET  = 8'h00;

  // status fields
  localparam int          ST_CRC_ERR_BIT  = 0;
  localparam int          ST_EOC_NEW_BIT  = 1;
  localparam int          ST_SEEN_BIT     = 2;

  // frame layout
  localparam int          POS_W           = 15;
  localparam int          SYNC_LEN        = 14;
  localparam int          EOC_LEN         = 13;
  localparam int          CRC_LEN         = 6;
  localparam int          STUFF_LEN       = 4;
  localparam logic [13:0] SYNC_WORD       = 14'h2a08;
  localparam logic [14:0] M_3PAIR         = 15'd4682;
  localparam logic [14:0] M_2PAIR         = 15'd6986;
  localparam logic [14:0] M_1PAIR         = 15'd13888;
  localparam logic [14:0] POS_EOC_LAST    = 15'd26;
  localparam logic [14:0] POS_CRC_LAST    = 15'd32;
  localparam logic [14:0] POS_UNUSED      = 15'd18;

  // maintenance addresses
  localparam logic [1:0]  EOC_ADDR_LINE   = 2'b11;
  localparam logic [1:0]  EOC_ADDR_CUST   = 2'b00;
  localparam logic [1:0]  EOC_ADDR_REGEN  = 2'b10;

  // scrambler
  localparam int          SCR_LEN         = 23;
  localparam int          TAP_LINE_TX     = 5;
  localparam int          TAP_CUST_TX     = 18;

  // crc generator low terms, x^6 + x + 1
  localparam logic [5:0]  CRC_POLY_LOW    = 6'h03;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_SYNC,
    TX_EOC,
    TX_CRC,
    TX_PAYLOAD,
    TX_STUFF
  } dfo_tx_state_t;

  function automatic logic [5:0] dfo_crc_step(input logic [5:0] r, input logic d);
    logic fb;
    fb = d ^ r[5];
    return {r[4:0], 1'b0} ^ (fb ? CRC_POLY_LOW : 6'h00);
  endfunction : dfo_crc_step

  function automatic logic [14:0] dfo_m_bits(input logic [1:0] cfg);
    if (cfg == 2'h1) begin
      return M_2PAIR;
    end else if (cfg == 2'h2) begin
      return M_1PAIR;
    end
    return M_3PAIR;
  endfunction : dfo_m_bits

endpackage : dfo_pkg

// file: src/dfo_scrambler.sv
// self-synchronising 23rd-order scrambler or descrambler
module dfo_scrambler
  import dfo_pkg::*;
#(
  parameter bit DESCRAMBLE = 1'b0
) (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // control
  input  wire logic en_in,
  input  wire logic line_tap_in,
  // data
  input  wire logic d_in,
  output logic      d_out
);

  logic [SCR_LEN-1:0] sr_reg;
  logic               fb;
  logic               line_bit;

  // line-side bit is what enters the delay line
  assign fb       = line_tap_in ? sr_reg[TAP_LINE_TX-1] : sr_reg[TAP_CUST_TX-1];
  assign d_out    = d_in ^ fb ^ sr_reg[SCR_LEN-1];
  assign line_bit = DESCRAMBLE ? d_in : d_out;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sr_reg <= '0;
    end else if (en_in) begin
      sr_reg <= {sr_reg[SCR_LEN-2:0], line_bit};
    end
  end

endmodule : dfo_scrambler

// file: src/dfo_peer.sv
// far-end peer: frame overhead transmit, receive check and apb registers
// Operation
// - every frame carries thirteen maintenance bits forming one whole maintenance frame
// - six crc bits per frame cover previous frame minus sync, crc, stuffing
// - crc covers 4682, 6986 or 13888 bits by pair configuration
// - covered bits in order, first highest power, times x^6, divided mod 2
// - remainder x^5 coefficient sent first, x^0 coefficient sent last
// - check bits belong to preceding frame; first frame may carry anything
// - alarm units clear alarm bit while pending; master may read their status (the peer sends no alarm bit and has no alarm status)
// - stuffing is none or a pair of quats, never scrambled
// - all data except sync and stuffing passes the 23rd-order scrambler
// - taps 23 and 18 upstream, 23 and 5 downstream, same to descramble
// - maintenance frame: address, data/opcode, odd/even, unused one, eight-bit info
// - addresses 11 line end, 00 customer end, 10 regenerator; echo own address
// - odd/even bit is one on first byte then alternates
//
// Local design decisions: the placing of the registers and the APB register port.
module dfo_peer
  import dfo_pkg::*;
#(
  parameter int ERR_CNT_W = 16
) (
  // clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RST_N_IN,
  // apb slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic             PREADY_OUT,
  output logic [31:0]      PRDATA_OUT,
  output logic             PSLVERR_OUT,
  // transmit line towards the device
  output logic             TX_BIT_OUT,
  output logic             TX_VALID_OUT,
  output logic             TX_SOF_OUT,
  output logic             TX_BYPASS_OUT,
  // receive line from the device
  input  wire logic        RX_BIT_IN,
  input  wire logic        RX_VALID_IN,
  input  wire logic        RX_SOF_IN,
  input  wire logic        RX_STUFF_IN
);

  typedef struct packed {
    logic [CTRL_W-1:0]    ctrl;
    logic [7:0]           eoc_info;
    logic                 eoc_dm;
    logic [1:0]           eoc_addr;
    logic                 odd_even;
    logic                 st_crc_err;
    logic                 st_eoc_new;
    logic [ERR_CNT_W-1:0] err_cnt;
    logic [EOC_LEN-1:0]   eoc_rx;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
    dfo_tx_state_t        tx_state;
    logic [POS_W-1:0]     tx_pos;
    logic                 tx_stuff_frame;
    logic [CTRL_W-1:0]    tx_ctrl;
    logic [CRC_LEN-1:0]   tx_crc_run;
    logic [CRC_LEN-1:0]   tx_crc_hold;
    logic [EOC_LEN-1:0]   tx_eoc_sh;
    logic                 tx_bit;
    logic                 tx_valid;
    logic                 tx_sof;
    logic                 tx_bypass;
    logic [POS_W-1:0]     rx_pos;
    logic                 rx_seen;
    logic                 rx_prev_valid;
    logic [CRC_LEN-1:0]   rx_crc_run;
    logic [CRC_LEN-1:0]   rx_crc_prev;
    logic [CRC_LEN-1:0]   rx_crc_got;
    logic [EOC_LEN-1:0]   rx_eoc_sh;
  } dfo_state_t;

  dfo_state_t       s_reg;
  dfo_state_t       s_next;

  logic             role_line;
  logic [POS_W-1:0] m_bits;
  logic             tx_scr_en;
  logic             tx_din;
  logic             tx_dout;
  logic             tx_covered;
  logic [POS_W-1:0] rx_idx;
  logic             rx_take;
  logic             rx_scr_en;
  logic             rx_d;
  logic             crc_mismatch;
  logic             apb_done;
  logic             wr_status;
  logic [1:0]       eoc_addr_eff;

  assign role_line    = s_reg.ctrl[CTRL_ROLE_BIT];
  assign m_bits       = dfo_m_bits(s_reg.tx_ctrl[CTRL_CFG_LSB+1:CTRL_CFG_LSB]);
  assign apb_done     = PSEL_IN && PENABLE_IN && s_reg.pready;
  assign wr_status    = apb_done && PWRITE_IN && (PADDR_IN == ADDR_STATUS);
  // own address when answering as customer end
  assign eoc_addr_eff = role_line ? s_reg.eoc_addr : EOC_ADDR_CUST;

  // transmit data bit ahead of scrambling
  always_comb begin
    tx_din     = s_reg.tx_ctrl[CTRL_FILL_BIT];
    tx_covered = 1'b0;
    tx_scr_en  = 1'b0;
    case (s_reg.tx_state)
      TX_EOC: begin
        tx_din     = s_reg.tx_eoc_sh[EOC_LEN-1];
        tx_covered = 1'b1;
        tx_scr_en  = 1'b1;
      end
      TX_CRC: begin
        tx_din    = s_reg.tx_crc_hold[CRC_LEN-1];
        tx_scr_en = 1'b1;
      end
      TX_PAYLOAD: begin
        tx_covered = 1'b1;
        tx_scr_en  = 1'b1;
      end
      default: begin
        tx_din = s_reg.tx_ctrl[CTRL_FILL_BIT];
      end
    endcase
  end

  dfo_scrambler #(
    .DESCRAMBLE (1'b0)
  ) u_tx_scr (
    .clk_in      (MCLK_IN),
    .rst_n_in    (RST_N_IN),
    .en_in       (tx_scr_en),
    .line_tap_in (s_reg.tx_ctrl[CTRL_ROLE_BIT]),
    .d_in        (tx_din),
    .d_out       (tx_dout)
  );

  // receive position, sof restarts the frame count
  assign rx_idx    = RX_SOF_IN ? '0 : s_reg.rx_pos;
  assign rx_take   = RX_VALID_IN && !RX_STUFF_IN;
  assign rx_scr_en = rx_take && (rx_idx >= POS_W'(SYNC_LEN));

  dfo_scrambler #(
    .DESCRAMBLE (1'b1)
  ) u_rx_scr (
    .clk_in      (MCLK_IN),
    .rst_n_in    (RST_N_IN),
    .en_in       (rx_scr_en),
    .line_tap_in (!role_line),
    .d_in        (RX_BIT_IN),
    .d_out       (rx_d)
  );

  assign crc_mismatch = rx_take && (rx_idx == POS_CRC_LAST) && s_reg.rx_prev_valid
                        && ({s_reg.rx_crc_got[CRC_LEN-2:0], rx_d} != s_reg.rx_crc_prev);

  always_comb begin
    s_next = s_reg;

    // apb: one wait state, action at the completing edge
    s_next.pready  = PSEL_IN && PENABLE_IN && !s_reg.pready;
    s_next.pslverr = 1'b0;
    s_next.prdata  = 32'h0;
    if (PSEL_IN && PENABLE_IN && !s_reg.pready) begin
      if (PADDR_IN == ADDR_CTRL) begin
        s_next.prdata[CTRL_W-1:0] = s_reg.ctrl;
      end else if (PADDR_IN == ADDR_EOC_TX) begin
        s_next.prdata[EOC_INFO_LSB+7:EOC_INFO_LSB] = s_reg.eoc_info;
        s_next.prdata[EOC_DM_BIT]                  = s_reg.eoc_dm;
        s_next.prdata[EOC_ADDR_LSB+1:EOC_ADDR_LSB] = s_reg.eoc_addr;
        s_next.prdata[EOC_OE_BIT]                  = s_reg.odd_even;
      end else if (PADDR_IN == ADDR_STATUS) begin
        s_next.prdata[ST_CRC_ERR_BIT] = s_reg.st_crc_err;
        s_next.prdata[ST_EOC_NEW_BIT] = s_reg.st_eoc_new;
        s_next.prdata[ST_SEEN_BIT]    = s_reg.rx_seen;
      end else if (PADDR_IN == ADDR_EOC_RX) begin
        s_next.prdata[EOC_LEN-1:0] = s_reg.eoc_rx;
      end else if (PADDR_IN == ADDR_ERR_CNT) begin
        s_next.prdata[ERR_CNT_W-1:0] = s_reg.err_cnt;
      end else begin
        s_next.pslverr = 1'b1;
      end
    end
    if (apb_done && PWRITE_IN) begin
      if (PADDR_IN == ADDR_CTRL) begin
        s_next.ctrl = PWDATA_IN[CTRL_W-1:0];
      end else if (PADDR_IN == ADDR_EOC_TX) begin
        s_next.eoc_info = PWDATA_IN[EOC_INFO_LSB+7:EOC_INFO_LSB];
        s_next.eoc_dm   = PWDATA_IN[EOC_DM_BIT];
        s_next.eoc_addr = PWDATA_IN[EOC_ADDR_LSB+1:EOC_ADDR_LSB];
        s_next.odd_even = PWDATA_IN[EOC_FIRST_BIT] ? 1'b1 : !s_reg.odd_even;
      end
    end
    // write one to clear, a same-cycle event wins
    if (wr_status && PWDATA_IN[ST_CRC_ERR_BIT]) begin
      s_next.st_crc_err = 1'b0;
    end
    if (wr_status && PWDATA_IN[ST_EOC_NEW_BIT]) begin
      s_next.st_eoc_new = 1'b0;
    end

    // transmit sequencer
    s_next.tx_bit    = tx_scr_en ? tx_dout : tx_din;
    s_next.tx_valid  = (s_reg.tx_state != TX_IDLE);
    s_next.tx_sof    = 1'b0;
    s_next.tx_bypass = !tx_scr_en && (s_reg.tx_state != TX_IDLE);
    s_next.tx_pos    = s_reg.tx_pos + POS_W'(1);
    if (tx_covered) begin
      s_next.tx_crc_run = dfo_crc_step(s_reg.tx_crc_run, tx_din);
    end
    case (s_reg.tx_state)
      TX_IDLE: begin
        s_next.tx_pos = '0;
      end
      TX_SYNC: begin
        s_next.tx_bit = SYNC_WORD[4'(SYNC_LEN - 1 - int'(s_reg.tx_pos))];
        s_next.tx_sof = (s_reg.tx_pos == '0);
        if (s_reg.tx_pos == POS_W'(SYNC_LEN - 1)) begin
          s_next.tx_state = TX_EOC;
        end
      end
      TX_EOC: begin
        s_next.tx_eoc_sh = {s_reg.tx_eoc_sh[EOC_LEN-2:0], 1'b1};
        if (s_reg.tx_pos == POS_EOC_LAST) begin
          s_next.tx_state = TX_CRC;
        end
      end
      TX_CRC: begin
        s_next.tx_crc_hold = {s_reg.tx_crc_hold[CRC_LEN-2:0], 1'b0};
        if (s_reg.tx_pos == POS_CRC_LAST) begin
          s_next.tx_state = TX_PAYLOAD;
        end
      end
      TX_PAYLOAD: begin
        if (s_reg.tx_pos == m_bits + POS_W'(SYNC_LEN + CRC_LEN - 1)) begin
          s_next.tx_state = s_reg.tx_stuff_frame ? TX_STUFF : TX_IDLE;
        end
      end
      TX_STUFF: begin
        if (s_reg.tx_pos == m_bits + POS_W'(SYNC_LEN + CRC_LEN + STUFF_LEN - 1)) begin
          s_next.tx_state = TX_IDLE;
        end
      end
      default: begin
        s_next.tx_state = TX_IDLE;
      end
    endcase
    // frame end hands remainder to the next frame
    if (s_reg.tx_state != TX_IDLE && s_next.tx_state == TX_IDLE) begin
      s_next.tx_crc_hold = s_next.tx_crc_run;
      s_next.tx_crc_run  = '0;
    end
    if (s_reg.ctrl[CTRL_EN_BIT] && s_next.tx_state == TX_IDLE) begin
      s_next.tx_state       = TX_SYNC;
      s_next.tx_pos         = '0;
      s_next.tx_stuff_frame = s_reg.ctrl[CTRL_STUFF_BIT];
      s_next.tx_ctrl        = s_reg.ctrl;
      s_next.tx_eoc_sh      = {eoc_addr_eff, s_reg.eoc_dm, s_reg.odd_even, 1'b1, s_reg.eoc_info};
    end

    // receive check
    if (rx_take) begin
      s_next.rx_pos = rx_idx + POS_W'(1);
      if (RX_SOF_IN) begin
        s_next.rx_seen       = 1'b1;
        s_next.rx_prev_valid = s_reg.rx_seen;
        s_next.rx_crc_prev   = s_reg.rx_crc_run;
        s_next.rx_crc_run    = '0;
      end else if (rx_idx >= POS_W'(SYNC_LEN) && rx_idx <= POS_EOC_LAST) begin
        s_next.rx_eoc_sh  = {s_reg.rx_eoc_sh[EOC_LEN-2:0], rx_d};
        s_next.rx_crc_run = dfo_crc_step(s_reg.rx_crc_run, rx_d);
        if (rx_idx == POS_EOC_LAST) begin
          s_next.eoc_rx     = {s_reg.rx_eoc_sh[EOC_LEN-2:0], rx_d};
          s_next.st_eoc_new = 1'b1;
        end
      end else if (rx_idx > POS_EOC_LAST && rx_idx <= POS_CRC_LAST) begin
        s_next.rx_crc_got = {s_reg.rx_crc_got[CRC_LEN-2:0], rx_d};
      end else if (rx_idx > POS_CRC_LAST) begin
        s_next.rx_crc_run = dfo_crc_step(s_reg.rx_crc_run, rx_d);
      end
    end
    if (crc_mismatch) begin
      s_next.st_crc_err = 1'b1;
      s_next.err_cnt    = s_reg.err_cnt + ERR_CNT_W'(1);
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_N_IN) begin
      s_reg          <= '0;
      s_reg.ctrl     <= CTRL_RESET;
      s_reg.eoc_info <= EOC_INFO_RESET;
      s_reg.eoc_addr <= EOC_ADDR_LINE;
      s_reg.odd_even <= 1'b1;
      s_reg.tx_state <= TX_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign PREADY_OUT    = s_reg.pready;
  assign PRDATA_OUT    = s_reg.prdata;
  assign PSLVERR_OUT   = s_reg.pslverr;
  assign TX_BIT_OUT    = s_reg.tx_bit;
  assign TX_VALID_OUT  = s_reg.tx_valid;
  assign TX_SOF_OUT    = s_reg.tx_sof;
  assign TX_BYPASS_OUT = s_reg.tx_bypass;

  // checks
  property p_sync_plain;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (s_reg.tx_state == TX_SYNC) |=> (TX_BYPASS_OUT && TX_BIT_OUT == SYNC_WORD[4'(13 - int'($past(s_reg.tx_pos)))]);
  endproperty
  a_sync_plain: assert property (p_sync_plain) else $error("sync bit wrong or scrambled");

  property p_crc_restart;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (s_reg.tx_state == TX_SYNC && s_reg.tx_pos == '0) |-> (s_reg.tx_crc_run == 6'h00);
  endproperty
  a_crc_restart: assert property (p_crc_restart) else $error("crc not restarted at frame");

  property p_frame_len;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (s_reg.tx_state == TX_PAYLOAD && s_next.tx_state != TX_PAYLOAD)
        |-> (s_reg.tx_pos == m_bits + 15'd19);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("covered length wrong");

  property p_stuff_pair;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      $rose(s_reg.tx_state == TX_STUFF) |-> (s_reg.tx_state == TX_STUFF)[*4] ##1 (s_reg.tx_state != TX_STUFF);
  endproperty
  a_stuff_pair: assert property (p_stuff_pair) else $error("stuffing not a quat pair");

  property p_unused_one;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (s_reg.tx_state == TX_EOC && s_reg.tx_pos == POS_UNUSED) |-> (tx_din == 1'b1 && tx_scr_en);
  endproperty
  a_unused_one: assert property (p_unused_one) else $error("unused maintenance bit not one");

  property p_first_frame_free;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (!s_reg.rx_prev_valid) |=> ($past(s_reg.err_cnt) == s_reg.err_cnt);
  endproperty
  a_first_frame_free: assert property (p_first_frame_free) else $error("error counted without previous frame");

  property p_mismatch_flag;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      crc_mismatch |=> (s_reg.st_crc_err && s_reg.err_cnt == $past(s_reg.err_cnt) + ERR_CNT_W'(1));
  endproperty
  a_mismatch_flag: assert property (p_mismatch_flag) else $error("crc mismatch not reported");

  property p_odd_even_first;
    @(posedge MCLK_IN) disable iff (!RST_N_IN)
      (apb_done && PWRITE_IN && PADDR_IN == ADDR_EOC_TX && PWDATA_IN[EOC_FIRST_BIT]) |=> s_reg.odd_even;
  endproperty
  a_odd_even_first: assert property (p_odd_even_first) else $error("first byte not odd");

endmodule : dfo_peer

// file: test/dfo_dev_model.sv
// behavioural line transceiver that sends frames to the peer
module dfo_dev_model
  import dfo_pkg::*;
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // control from the bench
  input  wire logic        en_in,
  input  wire logic        stuff_in,
  input  wire logic        bad_crc_in,
  input  wire logic [4:0]  tap_in,
  input  wire logic [12:0] eoc_in,
  // line towards the peer
  output logic             bit_out,
  output logic             valid_out,
  output logic             sof_out,
  output logic             stuff_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [22:0] hist;
  logic [5:0]  acc;
  logic [5:0]  crc_l;
  logic [12:0] eoc_l;
  logic        stuff_l;
  logic        bad_l;
  logic        d;
  logic        s;
  int          pos;
  always @(posedge clk_in) begin
    if (rst_n_in !== 1'b1) begin
      hist = 23'h0;
      acc = 6'h0;
      crc_l = 6'h0;
      pos = 0;
      valid_out <= 1'b0;
      sof_out <= 1'b0;
      stuff_out <= 1'b0;
      bit_out <= 1'b0;
    end else if (pos == 0 && en_in !== 1'b1) begin
      valid_out <= 1'b0;
      sof_out <= 1'b0;
      bit_out <= ~bit_out;
    end else begin
      if (pos == 0) begin
        eoc_l = eoc_in;
        stuff_l = stuff_in;
        bad_l = bad_crc_in;
      end
      valid_out <= 1'b1;
      sof_out <= (pos == 0);
      stuff_out <= (pos >= M_3PAIR + 20);
      if (pos < SYNC_LEN) begin
        bit_out <= SYNC_WORD[13 - pos];
      end else if (pos >= M_3PAIR + 20) begin
        bit_out <= pos[0];
      end else begin
        if (pos < 27) d = eoc_l[26 - pos];
        else if (pos < 33) d = crc_l[32 - pos] ^ (bad_l && pos == 27);
        else if (pos < 43) d = 1'b1;
        else d = 1'($urandom_range(1));
        if (pos < 27 || pos > 32) acc = {acc[4:0], 1'b0} ^ ((d ^ acc[5]) ? 6'h03 : 6'h00);
        s = d ^ hist[tap_in - 1] ^ hist[22];
        hist = {hist[21:0], s};
        bit_out <= s;
      end
      pos++;
      if (pos == M_3PAIR + 20 + (stuff_l ? 4 : 0)) begin
        pos = 0;
        crc_l = acc;
        acc = 6'h0;
      end
    end
  end
endmodule : dfo_dev_model

// file: test/testbench.sv
// self-checking bench for the frame overhead peer controller
module testbench
  import dfo_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, tx_bit, tx_valid, tx_sof, tx_byp;
  logic        rx_bit, rx_valid, rx_sof, rx_stuff;
  logic        mdl_en = 1'b0, mdl_stuff = 1'b0, mdl_bad = 1'b0;
  logic [12:0] mdl_eoc = 13'h0;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0;
  logic [5:0]  ctrl_sh = 6'h00;
  logic [1:0]  addr_sh = 2'b11;
  logic        oe_sh = 1'b1, dm_sh = 1'b0, d;
  logic [7:0]  info_sh = 8'h00;
  logic [22:0] hist = 23'h0;
  logic [5:0]  acc = 6'h0, crc_prev = 6'h0, crc_got = 6'h0, ctrl_l = 6'h0;
  logic [12:0] eoc_l = 13'h0;
  int          pos = 0, nfr = 0, nstuff = 0, npay = 0;

  dfo_peer DUT (
    .MCLK_IN(mclk), .RST_N_IN(rst_n),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr),
    .TX_BIT_OUT(tx_bit), .TX_VALID_OUT(tx_valid), .TX_SOF_OUT(tx_sof), .TX_BYPASS_OUT(tx_byp),
    .RX_BIT_IN(rx_bit), .RX_VALID_IN(rx_valid), .RX_SOF_IN(rx_sof), .RX_STUFF_IN(rx_stuff)
  );
  dfo_dev_model mdl (
    .clk_in(mclk), .rst_n_in(rst_n), .en_in(mdl_en), .stuff_in(mdl_stuff), .bad_crc_in(mdl_bad),
    .tap_in(5'd18), .eoc_in(mdl_eoc),
    .bit_out(rx_bit), .valid_out(rx_valid), .sof_out(rx_sof), .stuff_out(rx_stuff)
  );

  always #2 mclk = ~mclk;

  function automatic logic [5:0] check_bit_last(input logic [5:0] r, input logic b);
    return {r[4:0], 1'b0} ^ ((b ^ r[5]) ? 6'h03 : 6'h00);
  endfunction : check_bit_last

  function automatic int m_of(input logic [1:0] cfg);
    return (cfg == 2'h1) ? 6986 : ((cfg == 2'h2) ? 13888 : 4682);
  endfunction : m_of

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input logic [7:0] a, input logic [32:0] exp, input logic [31:0] mask);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(40'({err, rd & mask}), 40'(exp));
  endtask : rdc

  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic err_exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, v, rd, err);
    chk(40'(err), 40'(err_exp));
  endtask : wr

  task automatic weoc(input logic restart);
    dm_sh = 1'($urandom);
    info_sh = 8'($urandom);
    oe_sh = restart ? 1'b1 : ~oe_sh;
    wr(ADDR_EOC_TX, {19'h0, 1'b0, addr_sh, restart, dm_sh, info_sh}, 1'b0);
    rdc(ADDR_EOC_TX, 33'(oe_sh) << 12, 32'h1000);
  endtask : weoc

  task automatic sof_wait(input logic rx);
    do @(posedge mclk); while ((rx ? rx_sof : tx_sof) !== 1'b1);
    @(posedge mclk);
  endtask : sof_wait

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results

  // transmit line monitor
  always @(posedge mclk) begin
    if (tx_valid === 1'b1) begin
      if (tx_sof === 1'b1) begin
        if (nfr > 0) begin
          chk(40'(npay), 40'(m_of(ctrl_l[3:2]) - 13));
          chk(40'(nstuff), ctrl_l[4] ? 40'd4 : 40'd0);
        end
        if (nfr > 1) chk(40'(crc_got), 40'(crc_prev));
        crc_prev = acc;
        acc = 6'h0;
        pos = 0;
        nstuff = 0;
        npay = 0;
        nfr++;
        ctrl_l = ctrl_sh;
        eoc_l = {ctrl_sh[1] ? addr_sh : 2'b00, dm_sh, oe_sh, 1'b1, info_sh};
      end
      if (pos < 14) begin
        chk(40'({tx_byp, tx_bit}), 40'({1'b1, SYNC_WORD[13 - pos]}));
      end else if (tx_byp === 1'b1) begin
        nstuff++;
      end else begin
        d = tx_bit ^ hist[ctrl_l[1] ? 4 : 17] ^ hist[22];
        hist = {hist[21:0], tx_bit};
        if (pos < 27) chk(40'(d), 40'(eoc_l[26 - pos]));
        else if (pos < 33) crc_got[32 - pos] = d;
        else chk(40'(d), 40'(ctrl_l[5]));
        if (pos > 32) npay++;
        if (pos < 27 || pos > 32) acc = check_bit_last(acc, d);
      end
      pos++;
    end
  end

  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      results();
    end
  end

  initial begin
    void'($urandom(33478));
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(ADDR_CTRL, 33'h0, 32'hffff_ffff);
    rdc(ADDR_STATUS, 33'h0, 32'hffff_ffff);
    rdc(ADDR_ERR_CNT, 33'h0, 32'hffff_ffff);
    rdc(ADDR_EOC_TX, 33'h1000, 32'h1000);
    wr(8'h14, 32'hffff_ffff, 1'b1);
    rdc(8'h14, 33'h1_0000_0000, 32'hffff_ffff);
    mdl_stuff <= 1'($urandom);
    mdl_eoc <= {2'b00, 2'($urandom), 1'b1, 8'($urandom)};
    mdl_en <= 1'b1;
    weoc(1'b1);
    ctrl_sh = {1'($urandom), 1'b1, 2'b00, 1'b1, 1'b1};
    wr(ADDR_CTRL, 32'(ctrl_sh), 1'b0);
    rdc(ADDR_CTRL, 33'(ctrl_sh), 32'h3f);
    repeat (3) begin
      sof_wait(1'b0);
      weoc(1'b0);
    end
    sof_wait(1'b1);
    rdc(ADDR_STATUS, 33'h6, 32'h7);
    wr(ADDR_STATUS, 32'h2, 1'b0);
    rdc(ADDR_STATUS, 33'h4, 32'h7);
    rdc(ADDR_EOC_RX, 33'(mdl_eoc), 32'h1fff);
    rdc(ADDR_ERR_CNT, 33'h0, 32'hffff);
    mdl_bad <= 1'b1;
    sof_wait(1'b1);
    mdl_bad <= 1'b0;
    sof_wait(1'b1);
    rdc(ADDR_STATUS, 33'h1, 32'h1);
    rdc(ADDR_ERR_CNT, 33'h1, 32'hffff);
    wr(ADDR_STATUS, 32'h1, 1'b0);
    rdc(ADDR_STATUS, 33'h0, 32'h1);
    sof_wait(1'b0);
    ctrl_sh = {1'($urandom), 1'b0, 2'b01, 1'b0, 1'b1};
    wr(ADDR_CTRL, 32'(ctrl_sh), 1'b0);
    addr_sh = 2'b10;
    weoc(1'b1);
    repeat (3) sof_wait(1'b0);
    ctrl_sh[3:2] = 2'b10;
    wr(ADDR_CTRL, 32'(ctrl_sh), 1'b0);
    repeat (2) sof_wait(1'b0);
    results();
  end
endmodule : testbench
